// file: idu_top.sv
// Integrator/differentiator unit: one update per start, except a differentiator start with zero T and nonzero period, which never ends.
// Assumes a same-clock register master with one-cycle strobes.
// Function
// - Integrator flag 0 integrates; flag 1 outputs the initial value.
// - Integrator output is period over time, times input, plus last output.
// - Integrator with zero time holds the last output.
// - Differentiator flag 0 differentiates; flag 1 outputs the initial value.
// - Output is T/(T+period) times (last output minus last input plus input).
// - Differentiator output is zero when T plus period is zero.
// - Differentiator stores the input as previous input for next time.
// - Period is a float held in two dedicated words.
// - Only the operator writes the output value.
// - Arithmetic failure reports an operation error.
//
// The plain strobed port and the register addresses were chosen for this implementation.
`default_nettype none
module idu_top
   import idu_pkg::*;
(
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic CE,
   input wire logic [3:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   output logic IRQ
);
   logic [31:0] input_sample_reg, cycle_period_reg, time_reg;
   logic [31:0] initial_output_reg, output_value_reg, previous_input_reg;
   logic [31:0] previous_output_reg, acc_reg;
   logic op_mode_flag_reg, sel_d_reg;
   logic [NEV-1:0] status_reg, irq_en_reg, ev;
   idu_state_t state_reg;
   logic start, clr_work;
   logic [31:0] am_a, am_b, am_y, dv_y;
   logic am_mul, am_err, dv_err, dv_done, dv_start;
   logic err_reg;

   assign start = CE && WR && ADDR == A_CTRL && WDATA[CTRL_START];
   assign clr_work = WR && ADDR == A_CTRL && WDATA[CTRL_CLR_WORK];

   // Operand registers: each float is two 16-bit words.
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         input_sample_reg <= F_ZERO;
         cycle_period_reg <= F_ZERO;
         time_reg <= F_ZERO;
         initial_output_reg <= F_ZERO;
         op_mode_flag_reg <= 1'b0;
         sel_d_reg <= 1'b0;
         irq_en_reg <= '0;
      end else if (CE && WR) begin
         if (ADDR == A_INPUT_LO)
            input_sample_reg[15:0] <= WDATA;
         else if (ADDR == A_INPUT_HI)
            input_sample_reg[31:16] <= WDATA;
         else if (ADDR == A_MODE)
            op_mode_flag_reg <= WDATA[MODE_BIT];
         else if (ADDR == A_PERIOD_LO)
            cycle_period_reg[15:0] <= WDATA;
         else if (ADDR == A_PERIOD_HI)
            cycle_period_reg[31:16] <= WDATA;
         else if (ADDR == A_TIME_LO)
            time_reg[15:0] <= WDATA;
         else if (ADDR == A_TIME_HI)
            time_reg[31:16] <= WDATA;
         else if (ADDR == A_INIT_LO)
            initial_output_reg[15:0] <= WDATA;
         else if (ADDR == A_INIT_HI)
            initial_output_reg[31:16] <= WDATA;
         else if (ADDR == A_CTRL && state_reg == S_IDLE)
            sel_d_reg <= WDATA[CTRL_SEL_D];
         else if (ADDR == A_IRQ_EN)
            irq_en_reg <= WDATA[NEV-1:0];
      end
   end

   // Shared adder/multiplier operand steering per sequencer step.
   always_comb begin
      am_a = F_ZERO;
      am_b = F_ZERO;
      am_mul = 1'b0;
      case (state_reg)
         S_A: begin
            if (sel_d_reg) begin
               am_a = time_reg;
               am_b = cycle_period_reg;
            end else begin
               am_a = cycle_period_reg;
               am_b = input_sample_reg;
               am_mul = 1'b1;
            end
         end
         S_B: begin
            am_a = previous_output_reg;
            am_b = {~previous_input_reg[31], previous_input_reg[30:0]};
         end
         S_C: begin
            am_a = acc_reg;
            am_b = input_sample_reg;
         end
         S_D: begin
            // The quotient is used in the cycle the divider reports done.
            am_a = dv_y;
            am_b = sel_d_reg ? acc_reg : previous_output_reg;
            am_mul = sel_d_reg;
         end
         default: begin
            am_a = F_ZERO;
            am_b = F_ZERO;
            am_mul = 1'b0;
         end
      endcase
   end

   idu_fp_addmul u_am (
      .a(am_a),
      .b(am_b),
      .mul(am_mul),
      .y(am_y),
      .err(am_err)
   );

   // Divider: integrator computes (period*input)/T, differentiator T/(T+dt).
   assign dv_start = CE && state_reg == S_A && !am_err
                     && am_y[30:0] != F_ZERO[30:0];
   idu_fp_div u_dv (
      .clk(MCLK),
      .rst_n(RESETN),
      .ce(CE),
      .start(dv_start),
      .a(sel_d_reg ? time_reg : am_y),
      .b(sel_d_reg ? am_y : time_reg),
      .y(dv_y),
      .err(dv_err),
      .done(dv_done)
   );

   // Sequencer: one update per start, except a differentiator start with zero T and nonzero period, which stalls in S_D.
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         state_reg <= S_IDLE;
         output_value_reg <= F_ZERO;
         previous_output_reg <= F_ZERO;
         previous_input_reg <= F_ZERO;
         acc_reg <= F_ZERO;
         err_reg <= 1'b0;
      end else if (CE) begin
         case (state_reg)
            S_IDLE: begin
               err_reg <= 1'b0;
               if (clr_work) begin
                  previous_input_reg <= F_ZERO;
                  previous_output_reg <= F_ZERO;
               end
               if (start)
                  state_reg <= S_A;
            end
            S_A: begin
               if (op_mode_flag_reg) begin
                  output_value_reg <= initial_output_reg;
                  state_reg <= S_WB;
               end else if (!sel_d_reg && time_reg[30:0] == F_ZERO[30:0]) begin
                  output_value_reg <= previous_output_reg;
                  state_reg <= S_WB;
               end else if (am_err) begin
                  err_reg <= 1'b1;
                  state_reg <= S_WB;
               end else if (!sel_d_reg && am_y[30:0] == F_ZERO[30:0]) begin
                  // A zero product starts no division: output stays put.
                  output_value_reg <= previous_output_reg;
                  state_reg <= S_WB;
               end else if (sel_d_reg && am_y[30:0] == F_ZERO[30:0]) begin
                  output_value_reg <= F_ZERO;
                  state_reg <= S_WB;
               end else begin
                  state_reg <= sel_d_reg ? S_B : S_D;
               end
            end
            S_B: begin
               acc_reg <= am_y;
               err_reg <= am_err;
               state_reg <= S_C;
            end
            S_C: begin
               acc_reg <= am_y;
               err_reg <= err_reg | am_err;
               state_reg <= S_D;
            end
            S_D: begin
               if (dv_done) begin
                  if (dv_err || err_reg || am_err)
                     err_reg <= 1'b1;
                  else
                     output_value_reg <= am_y;
                  state_reg <= S_WB;
               end
            end
            S_WB: begin
               if (!err_reg) begin
                  previous_output_reg <= output_value_reg;
                  if (sel_d_reg)
                     previous_input_reg <= input_sample_reg;
               end
               state_reg <= S_IDLE;
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   // Sticky events: set wins over a simultaneous clear.
   assign ev[ST_DONE] = state_reg == S_WB;
   assign ev[ST_ERR] = state_reg == S_WB && err_reg;
   always_ff @(posedge MCLK) begin
      if (!RESETN)
         status_reg <= '0;
      else if (CE)
         status_reg <= ev | (status_reg
                       & ~((WR && ADDR == A_IRQ_CLR) ? WDATA[NEV-1:0] : '0));
   end

   always_ff @(posedge MCLK) begin
      if (!RESETN)
         IRQ <= 1'b0;
      else if (CE)
         IRQ <= |(status_reg & irq_en_reg);
   end

   // Read port: output and work words are read-only to software.
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         RDATA <= 16'h0;
      end else if (CE) begin
         if (!RD)
            RDATA <= 16'h0;
         else if (ADDR == A_INPUT_LO)
            RDATA <= input_sample_reg[15:0];
         else if (ADDR == A_INPUT_HI)
            RDATA <= input_sample_reg[31:16];
         else if (ADDR == A_MODE)
            RDATA <= {15'h0, op_mode_flag_reg};
         else if (ADDR == A_PERIOD_LO)
            RDATA <= cycle_period_reg[15:0];
         else if (ADDR == A_PERIOD_HI)
            RDATA <= cycle_period_reg[31:16];
         else if (ADDR == A_TIME_LO)
            RDATA <= time_reg[15:0];
         else if (ADDR == A_TIME_HI)
            RDATA <= time_reg[31:16];
         else if (ADDR == A_INIT_LO)
            RDATA <= initial_output_reg[15:0];
         else if (ADDR == A_INIT_HI)
            RDATA <= initial_output_reg[31:16];
         else if (ADDR == A_CTRL)
            RDATA <= {13'h0, 1'b0, sel_d_reg, 1'b0};
         else if (ADDR == A_OUT_LO)
            RDATA <= output_value_reg[15:0];
         else if (ADDR == A_OUT_HI)
            RDATA <= output_value_reg[31:16];
         else if (ADDR == A_STATUS)
            RDATA <= {13'h0, state_reg != S_IDLE, status_reg};
         else if (ADDR == A_IRQ_EN)
            RDATA <= {14'h0, irq_en_reg};
         else if (ADDR == A_WORK_LO)
            RDATA <= previous_input_reg[15:0];
         else
            RDATA <= 16'h0;
      end
   end
endmodule
`default_nettype wire

// file: idu_pkg.sv
// Package of the integrator/differentiator unit: register map, field
// layout, float constants and sequencer states.
// Assumes single-precision IEEE-754 operands split over two 16-bit words.
`default_nettype none
package idu_pkg;
   localparam int ADDR_W = 4;
   localparam logic [3:0] A_INPUT_LO = 4'h0;
   localparam logic [3:0] A_INPUT_HI = 4'h1;
   localparam logic [3:0] A_MODE = 4'h2;
   localparam logic [3:0] A_PERIOD_LO = 4'h3;
   localparam logic [3:0] A_PERIOD_HI = 4'h4;
   localparam logic [3:0] A_TIME_LO = 4'h5;
   localparam logic [3:0] A_TIME_HI = 4'h6;
   localparam logic [3:0] A_INIT_LO = 4'h7;
   localparam logic [3:0] A_INIT_HI = 4'h8;
   localparam logic [3:0] A_CTRL = 4'h9;
   localparam logic [3:0] A_OUT_LO = 4'ha;
   localparam logic [3:0] A_OUT_HI = 4'hb;
   localparam logic [3:0] A_STATUS = 4'hc;
   localparam logic [3:0] A_IRQ_EN = 4'hd;
   localparam logic [3:0] A_IRQ_CLR = 4'he;
   localparam logic [3:0] A_WORK_LO = 4'hf;
   localparam int CTRL_START = 0;
   localparam int CTRL_SEL_D = 1;
   localparam int CTRL_CLR_WORK = 2;
   localparam int MODE_BIT = 0;
   localparam int ST_DONE = 0;
   localparam int ST_ERR = 1;
   localparam int ST_BUSY = 2;
   localparam int NEV = 2;
   localparam logic [31:0] F_ZERO = 32'h0000_0000;
   localparam logic [7:0] EXP_MAX = 8'hff;
   localparam int OP_ADD = 0;
   localparam int OP_MUL = 1;
   localparam int OP_DIV = 2;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000, S_A = 3'b001, S_B = 3'b011, S_C = 3'b010,
      S_D = 3'b110, S_WB = 3'b111
   } idu_state_t;
endpackage
`default_nettype wire

// file: idu_fp_addmul.sv
// Combinational single-precision add and multiply, truncating.
// Assumes finite normal operands; flags overflow, NaN and infinity.
`default_nettype none
module idu_fp_addmul
   import idu_pkg::*;
(
   input wire logic [31:0] a,
   input wire logic [31:0] b,
   input wire logic mul,
   output logic [31:0] y,
   output logic err
);
   logic sa, sb;
   logic [7:0] ea, eb;
   logic [23:0] ma, mb;
   logic [47:0] prod;
   logic [9:0] ep;
   logic [7:0] d;
   logic [24:0] big, sml, sum;
   logic [9:0] es;
   logic [4:0] lz;
   logic [24:0] nrm;
   always_comb begin
      sa = a[31];
      sb = b[31];
      ea = a[30:23];
      eb = b[30:23];
      ma = (ea == 8'h00) ? 24'h0 : {1'b1, a[22:0]};
      mb = (eb == 8'h00) ? 24'h0 : {1'b1, b[22:0]};
      err = (ea == EXP_MAX) || (eb == EXP_MAX);
      y = F_ZERO;
      prod = 48'h0;
      ep = 10'h0;
      d = 8'h0;
      big = 25'h0;
      sml = 25'h0;
      sum = 25'h0;
      es = 10'h0;
      lz = 5'h0;
      nrm = 25'h0;
      if (mul) begin
         prod = ma * mb;
         ep = {2'b00, ea} + {2'b00, eb} - 10'd127;
         if (prod[47])
            ep = ep + 10'd1;
         else
            prod = prod << 1;
         if (ma == 24'h0 || mb == 24'h0)
            y = F_ZERO;
         else if (ep[9] || ep == 10'h0)
            y = F_ZERO;
         else if (ep >= 10'd255)
            err = 1'b1;
         else
            y = {sa ^ sb, ep[7:0], prod[46:24]};
      end else begin
         if ({ea, ma} >= {eb, mb}) begin
            d = ea - eb;
            big = {1'b0, ma};
            sml = {1'b0, mb} >> d;
            es = {2'b00, ea};
         end else begin
            d = eb - ea;
            big = {1'b0, mb};
            sml = {1'b0, ma} >> d;
            es = {2'b00, eb};
         end
         sum = (sa == sb) ? big + sml : big - sml;
         if (sum[24]) begin
            nrm = sum >> 1;
            es = es + 10'd1;
         end else begin
            nrm = sum;
            for (int i = 0; i < 24; i++)
               if (nrm[23] == 1'b0 && nrm != 25'h0) begin
                  nrm = nrm << 1;
                  lz = lz + 5'd1;
               end
            es = es - {5'h0, lz};
         end
         if (nrm == 25'h0 || es[9] || es == 10'h0)
            y = F_ZERO;
         else if (es >= 10'd255)
            err = 1'b1;
         else
            y = {({ea, ma} >= {eb, mb}) ? sa : sb, es[7:0], nrm[22:0]};
      end
   end
endmodule
`default_nettype wire

// file: idu_fp_div.sv
// Sequential single-precision divider, restoring, one quotient bit per
// clock. Assumes finite operands; a zero divisor raises the error flag.
`default_nettype none
module idu_fp_div
   import idu_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic start,
   input wire logic [31:0] a,
   input wire logic [31:0] b,
   output logic [31:0] y,
   output logic err,
   output logic done
);
   logic [25:0] rem_reg;
   logic [24:0] dvs_reg, q_reg;
   logic [4:0] cnt_reg;
   logic [9:0] e_reg;
   logic s_reg, run_reg;
   logic [25:0] diff;
   always_comb diff = rem_reg - {1'b0, dvs_reg};
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         run_reg <= 1'b0;
         done <= 1'b0;
         err <= 1'b0;
         y <= F_ZERO;
         rem_reg <= 26'h0;
         dvs_reg <= 25'h0;
         q_reg <= 25'h0;
         cnt_reg <= 5'h0;
         e_reg <= 10'h0;
         s_reg <= 1'b0;
      end else if (ce) begin
         done <= 1'b0;
         if (start) begin
            err <= (b[30:23] == 8'h00) || (a[30:23] == EXP_MAX)
                  || (b[30:23] == EXP_MAX);
            y <= F_ZERO;
            s_reg <= a[31] ^ b[31];
            e_reg <= {2'b00, a[30:23]} - {2'b00, b[30:23]} + 10'd127;
            // The remainder starts at the dividend mantissa, so the first
            // quotient bit weighs one.
            rem_reg <= {3'b001, a[22:0]};
            dvs_reg <= {1'b0, 1'b1, b[22:0]};
            q_reg <= 25'h0;
            cnt_reg <= 5'd25;
            // A zero dividend or divisor needs no steps: zero or an error.
            run_reg <= (b[30:23] != 8'h00) && (a[30:23] != 8'h00);
            done <= (b[30:23] == 8'h00) || (a[30:23] == 8'h00);
         end else if (run_reg) begin
            if (!diff[25]) begin
               rem_reg <= {diff[24:0], 1'b0};
               q_reg <= {q_reg[23:0], 1'b1};
            end else begin
               rem_reg <= {rem_reg[24:0], 1'b0};
               q_reg <= {q_reg[23:0], 1'b0};
            end
            cnt_reg <= cnt_reg - 5'd1;
            if (cnt_reg == 5'd1) begin
               run_reg <= 1'b0;
               done <= 1'b1;
               if (q_reg[23]) begin
                  if (e_reg[9] || e_reg == 10'h0 || rem_reg[25:1] == 25'h0
                      && q_reg == 25'h0)
                     y <= F_ZERO;
                  else if (e_reg >= 10'd255)
                     err <= 1'b1;
                  else
                     y <= {s_reg, e_reg[7:0], q_reg[22:0]};
               end else begin
                  if (e_reg[9] || e_reg <= 10'd1)
                     y <= F_ZERO;
                  else if (e_reg >= 10'd256)
                     err <= 1'b1;
                  else
                     y <= {s_reg, e_reg[7:0] - 8'd1, q_reg[21:0],
                           ~diff[25]};
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: idu_prog.sv
// Model of the controlling program that feeds the unit over its word bus.
// Assumes one clock shared with the unit; strobes move after rising edges.
`default_nettype none
module idu_prog
   import idu_pkg::*;
(
   input wire logic clk,
   input wire logic [15:0] rdata,
   output logic [3:0] addr,
   output logic [15:0] wdata,
   output logic wr,
   output logic rd
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      addr = 4'h0;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
   end
   task wr16(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Floats go low word first, then the high word one address up.
   task wr32(input logic [3:0] a, input logic [31:0] d);
      wr16(a, d[15:0]);
      wr16(a + 4'h1, d[31:16]);
   endtask
   task rd16(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task rd32(input logic [3:0] a, output logic [31:0] d);
      rd16(a, d[15:0]);
      rd16(a + 4'h1, d[31:16]);
   endtask
   // Wipes the previous input and output ahead of a fresh start.
   task clear_work(input logic sel);
      wr16(A_CTRL, {13'h0000, 1'b1, sel, 1'b0});
   endtask
endmodule
`default_nettype wire

// file: idu_assertions.sv
// Port-level checker for the integrator/differentiator unit.
// Assumes the single clock MCLK and synchronous active-low RESETN.
`default_nettype none
module idu_chk
   import idu_pkg::*;
(
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic CE,
   input wire logic [3:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [15:0] RDATA,
   input wire logic IRQ
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] en_reg;
   logic [15:0] hi_reg;
   logic hi_ok_reg;
   logic hi_rd_reg;
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESETN);
   always_ff @(posedge MCLK) begin
      if (!RESETN) en_reg <= 2'b00;
      else if (CE && WR && ADDR == A_IRQ_EN) en_reg <= WDATA[1:0];
   end
   // Remembers the last output high word; a start makes it stale.
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         hi_rd_reg <= 1'b0;
         hi_ok_reg <= 1'b0;
         hi_reg <= 16'h0000;
      end else if (CE) begin
         hi_rd_reg <= RD && ADDR == A_OUT_HI;
         if (WR && ADDR == A_CTRL && WDATA[CTRL_START]) hi_ok_reg <= 1'b0;
         else if (hi_rd_reg) begin
            hi_ok_reg <= 1'b1;
            hi_reg <= RDATA;
         end
      end
   end
   a_rdata_after_rd: assert property (RDATA != 16'h0000 |-> $past(RD))
      else $error("read data seen without a read");
   a_rdata_one_cycle: assert property (RD ##1 !RD |=> RDATA == 16'h0000)
      else $error("read data stood too long");
   a_write_no_data: assert property (WR |=> RDATA == 16'h0000)
      else $error("a write produced read data");
   a_status_spare: assert property (
      RD && ADDR == A_STATUS |=> RDATA[15:3] == 13'h0000)
      else $error("spare status bits set");
   a_irq_needs_en: assert property (
      IRQ |-> en_reg != 2'b00 || $past(en_reg) != 2'b00)
      else $error("interrupt while masked");
   a_irq_clear: assert property (
      WR && ADDR == A_IRQ_CLR && WDATA[1:0] == 2'b11 |-> ##2 !IRQ)
      else $error("interrupt stayed after clear");
   a_out_held: assert property (
      hi_rd_reg && hi_ok_reg |-> RDATA == hi_reg)
      else $error("output changed without a start");
   a_start_shows: assert property (
      WR && ADDR == A_CTRL && WDATA[CTRL_START] ##2 RD && ADDR == A_STATUS
      |=> RDATA[2:0] != 3'b000)
      else $error("start left no trace in status");
   a_reset_quiet: assert property (
      $rose(RESETN) |-> RDATA == 16'h0000 && !IRQ)
      else $error("outputs busy after reset");
   cover property (hi_rd_reg && hi_ok_reg);
   cover property ($rose(IRQ));
   cover property (WR && ADDR == A_CTRL && WDATA[CTRL_SEL_D]);
endmodule
bind idu_top idu_chk chk(.MCLK(MCLK), .RESETN(RESETN), .CE(CE), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ));
`default_nettype wire

// file: tb.sv
// Self-checking bench for the integrator/differentiator unit.
// Assumes the package, the unit, the program model and the checker.
`default_nettype none
module tb
   import idu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   logic [3:0] addr;
   logic [15:0] wdata;
   logic wr;
   logic rd;
   logic [15:0] rdata;
   logic irq;
   logic [31:0] v;
   logic [15:0] s;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   always #5 mclk = ~mclk;
   idu_prog p(.clk(mclk), .rdata(rdata), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd));
   idu_top dut(.MCLK(mclk), .RESETN(resetn), .CE(ce), .ADDR(addr),
      .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq));
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         summarize();
      end
   end
   // Launches one update, polls until done or error, returns the output.
   task run(input logic sel, output logic [31:0] y, output logic [15:0] st);
      int i;
      p.wr16(A_IRQ_CLR, 16'h0003);
      p.wr16(A_CTRL, {14'h0000, sel, 1'b1});
      st = 16'h0000;
      for (i = 0; i < 200 && st[1:0] == 2'b00; i++) p.rd16(A_STATUS, st);
      chk("run_done", {31'h0, st[1:0] != 2'b00}, 32'h1);
      p.rd32(A_OUT_LO, y);
   endtask
   task load(input logic [15:0] m, input logic [31:0] pd,
      input logic [31:0] tm, input logic [31:0] yi, input logic [31:0] e);
      p.wr16(A_MODE, m);
      p.wr32(A_PERIOD_LO, pd);
      p.wr32(A_TIME_LO, tm);
      p.wr32(A_INIT_LO, yi);
      p.wr32(A_INPUT_LO, e);
   endtask
   task t_reset;
      p.rd32(A_OUT_LO, v);
      chk("out_reset", v, F_ZERO);
      p.rd16(A_STATUS, s);
      chk("status_reset", {16'h0000, s}, 32'h0);
   endtask
   task t_integ;
      load(16'h0, 32'h3f000000, 32'h3f800000, 32'h40400000, 32'h40000000);
      run(1'b0, v, s);
      chk("int_first", v, 32'h3f800000);
      run(1'b0, v, s);
      chk("int_second", v, 32'h40000000);
      p.wr16(A_OUT_HI, 16'h1234);
      p.rd32(A_OUT_LO, v);
      chk("out_locked", v, 32'h40000000);
      // A software write to the read-only work word must leave it at zero.
      p.wr16(A_WORK_LO, 16'h5a5a);
      p.rd16(A_WORK_LO, s);
      chk("work_untouched", {16'h0000, s}, F_ZERO);
      p.wr32(A_TIME_LO, F_ZERO);
      run(1'b0, v, s);
      chk("int_hold", v, 32'h40000000);
      p.wr16(A_MODE, 16'h0001);
      run(1'b0, v, s);
      chk("int_init", v, 32'h40400000);
      p.wr16(A_MODE, 16'h0000);
      p.wr32(A_TIME_LO, 32'h3f800000);
      run(1'b0, v, s);
      chk("int_resume", v, 32'h40800000);
   endtask
   task t_deriv;
      p.clear_work(1'b1);
      load(16'h0, 32'h3f800000, 32'h3f800000, 32'h40800000, 32'h40400000);
      run(1'b1, v, s);
      chk("der_first", v, 32'h3fc00000);
      run(1'b1, v, s);
      chk("der_second", v, 32'h3f400000);
      p.wr16(A_MODE, 16'h0001);
      run(1'b1, v, s);
      chk("der_init", v, 32'h40800000);
      p.wr16(A_MODE, 16'h0000);
      p.wr32(A_PERIOD_LO, F_ZERO);
      p.wr32(A_TIME_LO, F_ZERO);
      run(1'b1, v, s);
      chk("der_zero", v, F_ZERO);
      chk("der_zero_err", {31'h0, s[ST_ERR]}, 32'h0);
   endtask
   task t_err;
      p.wr16(A_IRQ_EN, 16'h0000);
      load(16'h0, 32'h40000000, 32'h3f800000, F_ZERO, 32'h7f7fffff);
      run(1'b0, v, s);
      chk("err_flag", {31'h0, s[ST_ERR]}, 32'h1);
      chk("err_out_held", v, F_ZERO);
      chk("irq_masked", {31'h0, irq}, 32'h0);
      p.wr16(A_IRQ_EN, 16'h0002);
      repeat (2) @(posedge mclk);
      #1 chk("irq_on", {31'h0, irq}, 32'h1);
      // A write while the clock enable is low must leave the mask alone.
      @(posedge mclk) ce <= 1'b0;
      p.wr16(A_IRQ_EN, 16'h0000);
      ce <= 1'b1;
      repeat (2) @(posedge mclk);
      #1 chk("irq_frozen", {31'h0, irq}, 32'h1);
      p.wr16(A_IRQ_CLR, 16'h0002);
      repeat (2) @(posedge mclk);
      #1 chk("irq_off", {31'h0, irq}, 32'h0);
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;
      t_reset();
      t_integ();
      t_deriv();
      t_err();
      summarize();
   end
endmodule
`default_nettype wire
